//--- rtl/ddio_consts.svh
// Constants of the drive digital I/O object block
`ifndef DDIO_CONSTS_SVH
`define DDIO_CONSTS_SVH

// Object dictionary addressing
`define DDIO_IDX_INPUTS      16'h60fd
`define DDIO_IDX_OUTPUTS     16'h60fe
`define DDIO_SUB_COUNT       8'h00
`define DDIO_SUB_PHYS        8'h01
`define DDIO_SUB_MASK        8'h02
`define DDIO_ENTRY_COUNT     32'h0000_0002

// Writable bits of the output and mask words
`define DDIO_OUT_WR_MASK     32'h0f1f_0000
`define DDIO_WORD_RST        32'h0000_0000

// Input word layout
`define DDIO_IN_NEG_OT       0
`define DDIO_IN_POS_OT       1
`define DDIO_IN_HOME         2
`define DDIO_IN_GP_LSB       16

// Output word layout
`define DDIO_OUT_GP_LSB      16
`define DDIO_OUT_RM_LSB      24

// Sizes
`define DDIO_N_CONN_IN       5
`define DDIO_N_CONN_OUT      4
`define DDIO_N_FUNC          8
`define DDIO_N_REMOTE        4
`define DDIO_N_SYNC          8
`define DDIO_NIB             4

// Allocation codes
`define DDIO_ALLOC_REMOTE    4'hf
`define DDIO_SRC_BUS         4'h8
`define DDIO_REM_NONE        4'h0

// Levels and reset values
`define DDIO_LEVEL_OFF       1'b1
`define DDIO_PIN_RST         4'hf
`define DDIO_FUNC_RST        8'hff
`define DDIO_SYNC_RST        8'h00

`endif

//--- rtl/ddio_pkg.sv
// Types of the drive digital I/O object block
`include "ddio_consts.svh"

package ddio_pkg;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] index;
      logic [7:0]  subindex;
      logic [31:0] wdata;
   } ddio_od_req_t;

   typedef struct packed {
      logic        ack;
      logic        abort;
      logic [31:0] rdata;
   } ddio_od_rsp_t;

   typedef struct packed {
      logic [`DDIO_N_SYNC-1:0]     sync1;
      logic [`DDIO_N_SYNC-1:0]     sync2;
      logic [31:0]                 out_word;
      logic [31:0]                 mask_word;
      ddio_od_rsp_t                rsp;
      logic [`DDIO_N_CONN_OUT-1:0] conn_out;
      logic [`DDIO_N_FUNC-1:0]     func_in_b;
   } ddio_state_t;

endpackage : ddio_pkg

//--- rtl/ddio_out_slot.sv
// Source selection and polarity of one connector output
`timescale 1ns/1ps
`include "ddio_consts.svh"

module ddio_out_slot (
   input  wire logic [3:0]                 src_sel,
   input  wire logic [3:0]                 rem_sel,
   input  wire logic                       invert,
   input  wire logic                       gp_bit,
   input  wire logic                       gp_mask,
   input  wire logic                       gp_en,
   input  wire logic [`DDIO_N_REMOTE-1:0]  rem_bits,
   input  wire logic [`DDIO_N_REMOTE-1:0]  rem_mask,
   input  wire logic [`DDIO_N_REMOTE-1:0]  rem_en,
   input  wire logic [`DDIO_N_FUNC-1:0]    func_out,
   output logic                            level
);
   import ddio_pkg::*;

   logic [3:0] rem_idx;

   always_comb begin
      rem_idx = rem_sel - 4'h1;
      level   = `DDIO_LEVEL_OFF;
      if (rem_sel != `DDIO_REM_NONE) begin
         // Remote slot: master owns it, no polarity reversal
         if (rem_idx < 4'(`DDIO_N_REMOTE)) begin
            if (rem_mask[rem_idx[1:0]] && rem_en[rem_idx[1:0]]) begin
               level = rem_bits[rem_idx[1:0]];
            end
         end
      end else begin
         if (src_sel == `DDIO_SRC_BUS) begin
            if (gp_mask && gp_en) begin
               level = gp_bit;
            end
         end else if (src_sel < 4'(`DDIO_N_FUNC)) begin
            level = func_out[src_sel[2:0]];
         end
         level = level ^ invert;
      end
   end

endmodule // ddio_out_slot

//--- rtl/ddio_top.sv
// Digital input image and bus-driven outputs of the servo drive
`timescale 1ns/1ps
`include "ddio_consts.svh"

// Notes on behaviour
// - Input bits 0..2 give negative, positive overtravel and home; 1 is on.
// - Input bits 16..20 give five connector inputs; 0 active, 1 inactive.
// - Inputs allocated remote only show in the word, drive ignores them.
// - Output levels come from the physical-outputs word, subindex 1.
// - A physical-outputs bit applies only with its mask bit set.
// - Bits 16..19 feed general outputs, placed by the allocation setting.
// - Each general output is inverted when its polarity bit is set.
// - Bus bits reach an output only when bus-enable bits allow them.
// - Bits 24..27 feed connector outputs allocated as remote outputs.
// - Output bits 16..20 and 24..27: 0 is active, 1 is inactive.
module ddio_top (
   input  wire logic                         core_clk,
   input  wire logic                         rst_b,
   input  wire ddio_pkg::ddio_od_req_t       od_req,
   output ddio_pkg::ddio_od_rsp_t            od_rsp,
   input  wire logic                         neg_ot_pin,
   input  wire logic                         pos_ot_pin,
   input  wire logic                         home_pin,
   input  wire logic [`DDIO_N_CONN_IN-1:0]   conn_in_pin,
   input  wire logic [`DDIO_N_FUNC-1:0]      drive_func_out,
   input  wire logic [19:0]                  input_allocation_param_a,
   input  wire logic [15:0]                  input_allocation_param_b,
   input  wire logic [15:0]                  remote_output_allocation_param,
   input  wire logic [3:0]                   bus_output_enable_param_a,
   input  wire logic [3:0]                   bus_output_enable_param_b,
   input  wire logic [3:0]                   output_polarity_param_a,
   output logic [`DDIO_N_CONN_OUT-1:0]       conn_out_pin,
   output logic [`DDIO_N_FUNC-1:0]           func_in_b
);
   import ddio_pkg::*;

   // ************************************************************
   // State
   // ************************************************************

   ddio_state_t                  state_reg;
   ddio_state_t                  state_next;

   logic [31:0]                  input_image;
   logic [`DDIO_N_CONN_OUT-1:0]  slot_level;
   logic [`DDIO_N_REMOTE-1:0]    rem_bits;
   logic [`DDIO_N_REMOTE-1:0]    rem_mask;
   logic [`DDIO_N_CONN_IN-1:0]   conn_in_sync;
   logic [`DDIO_N_CONN_IN-1:0]   in_remote;
   logic [`DDIO_N_CONN_IN*4-1:0] in_alloc;

   assign rem_bits = state_reg.out_word[`DDIO_OUT_RM_LSB +: `DDIO_N_REMOTE];
   assign rem_mask = state_reg.mask_word[`DDIO_OUT_RM_LSB +: `DDIO_N_REMOTE];

   // Allocation nibbles: inputs 0..4 from setting a, all five nibbles used
   assign in_alloc = input_allocation_param_a;

   // Second stage of the pin synchronisers only
   assign conn_in_sync =
      state_reg.sync2[`DDIO_N_CONN_IN-1:0];

   // ************************************************************
   // Input image
   // ************************************************************

   always_comb begin
      input_image = `DDIO_WORD_RST;
      input_image[`DDIO_IN_NEG_OT] =
         state_reg.sync2[`DDIO_N_CONN_IN];
      input_image[`DDIO_IN_POS_OT] =
         state_reg.sync2[`DDIO_N_CONN_IN + 1];
      input_image[`DDIO_IN_HOME] =
         state_reg.sync2[`DDIO_N_CONN_IN + 2];
      // Remote inputs are still reported to the master
      input_image[`DDIO_IN_GP_LSB +: `DDIO_N_CONN_IN] =
         conn_in_sync;
   end

   // ************************************************************
   // Output slots
   // ************************************************************

   genvar k;
   generate
      for (k = 0; k < `DDIO_N_CONN_OUT; k = k + 1) begin : g_slot
         ddio_out_slot u_slot (
            .src_sel  (input_allocation_param_b[k*4 +: 4]),
            .rem_sel  (remote_output_allocation_param[k*4 +: 4]),
            .invert   (output_polarity_param_a[k]),
            .gp_bit   (state_reg.out_word[`DDIO_OUT_GP_LSB + k]),
            .gp_mask  (state_reg.mask_word[`DDIO_OUT_GP_LSB + k]),
            .gp_en    (bus_output_enable_param_a[k]),
            .rem_bits (rem_bits),
            .rem_mask (rem_mask),
            .rem_en   (bus_output_enable_param_b),
            .func_out (drive_func_out),
            .level    (slot_level[k])
         );
      end
   endgenerate

   // ************************************************************
   // Next state
   // ************************************************************

   always_comb begin
      logic       hit_in;
      logic       hit_out;
      logic [3:0] code;
      logic       active;

      state_next = state_reg;
      hit_in     = 1'b0;
      hit_out    = 1'b0;
      code       = 4'h0;
      active     = 1'b0;

      // Two-flop synchronisers for every pin input
      state_next.sync1 = {home_pin, pos_ot_pin, neg_ot_pin, conn_in_pin};
      state_next.sync2 = state_reg.sync1;

      // Inputs allocated remote never reach drive functions
      for (int i = 0; i < `DDIO_N_CONN_IN; i++) begin
         in_remote[i] =
            (in_alloc[i*4 +: 4] == `DDIO_ALLOC_REMOTE);
      end

      // Function input is active low: any owning input at 0 asserts it
      for (int j = 0; j < `DDIO_N_FUNC; j++) begin
         active = 1'b0;
         for (int i = 0; i < `DDIO_N_CONN_IN; i++) begin
            code = in_alloc[i*4 +: 4];
            if (!in_remote[i] && code == 4'(j) && !conn_in_sync[i]) begin
               active = 1'b1;
            end
         end
         state_next.func_in_b[j] = ~active;
      end

      state_next.conn_out = slot_level;

      // Object access: answer one cycle after the request
      state_next.rsp = '0;
      if (od_req.valid) begin
         hit_in  = (od_req.index == `DDIO_IDX_INPUTS);
         hit_out = (od_req.index == `DDIO_IDX_OUTPUTS);
         state_next.rsp.ack = 1'b1;
         if (hit_in && od_req.subindex == `DDIO_SUB_COUNT) begin
            if (od_req.write) begin
               state_next.rsp.abort = 1'b1;
            end else begin
               state_next.rsp.rdata = input_image;
            end
         end else if (hit_out) begin
            case (od_req.subindex)
               `DDIO_SUB_COUNT: begin
                  if (od_req.write) begin
                     state_next.rsp.abort = 1'b1;
                  end else begin
                     state_next.rsp.rdata = `DDIO_ENTRY_COUNT;
                  end
               end
               `DDIO_SUB_PHYS: begin
                  if (od_req.write) begin
                     state_next.out_word =
                        od_req.wdata & `DDIO_OUT_WR_MASK;
                  end else begin
                     state_next.rsp.rdata = state_reg.out_word;
                  end
               end
               `DDIO_SUB_MASK: begin
                  if (od_req.write) begin
                     state_next.mask_word =
                        od_req.wdata & `DDIO_OUT_WR_MASK;
                  end else begin
                     state_next.rsp.rdata = state_reg.mask_word;
                  end
               end
               default: begin
                  state_next.rsp.abort = 1'b1;
               end
            endcase
         end else begin
            // Unknown object or subindex
            state_next.rsp.abort = 1'b1;
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg.sync1     <= `DDIO_SYNC_RST;
         state_reg.sync2     <= `DDIO_SYNC_RST;
         state_reg.out_word  <= `DDIO_WORD_RST;
         state_reg.mask_word <= `DDIO_WORD_RST;
         state_reg.rsp       <= '0;
         state_reg.conn_out  <= `DDIO_PIN_RST;
         state_reg.func_in_b <= `DDIO_FUNC_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign od_rsp       = state_reg.rsp;
   assign conn_out_pin = state_reg.conn_out;
   assign func_in_b    = state_reg.func_in_b;

endmodule // ddio_top

//--- dv/ddio_top_asserts.sv
// Port assertions of the digital I/O object block
`timescale 1ns/1ps
`include "ddio_consts.svh"
// ****************************************
// Checker
// ****************************************
module ddio_top_asserts (
   input wire logic                   core_clk,
   input wire logic                   rst_b,
   input wire ddio_pkg::ddio_od_req_t od_req,
   input wire ddio_pkg::ddio_od_rsp_t od_rsp,
   input wire logic                   neg_ot_pin,
   input wire logic                   pos_ot_pin,
   input wire logic                   home_pin,
   input wire logic [4:0]             conn_in_pin,
   input wire logic [19:0]            input_allocation_param_a,
   input wire logic [15:0]            input_allocation_param_b,
   input wire logic [15:0]            remote_output_allocation_param,
   input wire logic [3:0]             bus_output_enable_param_a,
   input wire logic [3:0]             output_polarity_param_a,
   input wire logic [3:0]             conn_out_pin,
   input wire logic [7:0]             func_in_b
);
   import ddio_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [3:0] pins_in;
   logic       rd_in;
   assign pins_in = {home_pin, pos_ot_pin, neg_ot_pin, 1'b0};
   assign rd_in = od_req.valid && !od_req.write &&
      od_req.index == `DDIO_IDX_INPUTS && od_req.subindex == 8'h00;
   a_ack_follows: assert property (
      od_req.valid |=> od_rsp.ack) else $error("request not answered");
   a_ack_alone: assert property (
      !od_req.valid |=> !od_rsp.ack) else $error("answer without request");
   a_input_ro: assert property (
      od_req.valid && od_req.write && od_req.index == `DDIO_IDX_INPUTS
      |=> od_rsp.ack && od_rsp.abort) else $error("input word written");
   a_rsvd_zero: assert property (
      od_rsp.ack |-> (od_rsp.rdata & 32'hf0e0fff8) == 32'h0)
      else $error("reserved read bits set");
   a_switch_bits: assert property (
      $stable({conn_in_pin, pins_in})[*4] ##0 rd_in |=>
      od_rsp.rdata[20:0] == {$past(conn_in_pin), 13'h0, $past(pins_in[3:1])})
      else $error("input image wrong");
   a_bus_gated: assert property (
      (bus_output_enable_param_a == 4'h0 && output_polarity_param_a == 4'h0
      && remote_output_allocation_param == 16'h0 &&
      input_allocation_param_b == 16'h8888)[*2] |-> conn_out_pin == 4'hf)
      else $error("disabled bus bit reached an output");
   a_remote_ign: assert property (
      (input_allocation_param_a == 20'hfffff)[*2] |-> func_in_b == 8'hff)
      else $error("remote input used by drive");
   a_reset_idle: assert property (
      $rose(rst_b) |-> conn_out_pin == 4'hf && !od_rsp.ack)
      else $error("outputs not idle after reset");
endmodule // ddio_top_asserts

bind ddio_top ddio_top_asserts i_ddio_top_asserts (.core_clk, .rst_b,
   .od_req, .od_rsp, .neg_ot_pin, .pos_ot_pin, .home_pin, .conn_in_pin,
   .input_allocation_param_a, .input_allocation_param_b,
   .remote_output_allocation_param, .bus_output_enable_param_a,
   .output_polarity_param_a, .conn_out_pin, .func_in_b);

//--- dv/ddio_master_model.sv
// Fieldbus master model issuing object requests
`timescale 1ns/1ps
// ****************************************
// Master
// ****************************************
module ddio_master_model (
   input  wire logic                   core_clk,
   output ddio_pkg::ddio_od_req_t      od_req,
   input  wire ddio_pkg::ddio_od_rsp_t od_rsp
);
   import ddio_pkg::*;
   initial od_req = '0;
   // Each valid cycle is a request, so valid drops after one edge
   task automatic xfer(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [31:0] d, output ddio_od_rsp_t r);
      @(posedge core_clk);
      od_req <= {1'b1, w, i, s, d};
      @(posedge core_clk);
      od_req <= {1'b0, ~od_req[56:0]};
      #1;
      r = od_rsp;
   endtask
endmodule // ddio_master_model

//--- dv/ddio_top_test.sv
// Self-checking bench of the digital I/O object block
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module ddio_top_test;
   import ddio_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst_b = 1'b0;
   ddio_od_req_t od_req;
   ddio_od_rsp_t od_rsp;
   logic [2:0]   sw = 3'h0;
   logic [4:0]   cin = 5'h1f;
   logic [7:0]   fo = 8'h5a;
   logic [19:0]  ia = 20'h43210;
   logic [15:0]  ib = 16'h8888;
   logic [15:0]  ro = 16'h0;
   logic [3:0]   ea = 4'h0;
   logic [3:0]   eb = 4'h0;
   logic [3:0]   pol = 4'h0;
   logic [3:0]   pins;
   logic [7:0]   fin;
   logic [7:0]   pat [2] = '{8'ha5, 8'h5a};
   int           n_errors = 0;
   int           num_checks = 0;
   int           cyc = 0;
   always #5 core_clk = ~core_clk;
   ddio_master_model i_ddio_master_model (.core_clk, .od_req, .od_rsp);
   ddio_top i_ddio_top (.core_clk, .rst_b, .od_req, .od_rsp,
      .neg_ot_pin(sw[0]), .pos_ot_pin(sw[1]), .home_pin(sw[2]),
      .conn_in_pin(cin), .drive_func_out(fo),
      .input_allocation_param_a(ia), .input_allocation_param_b(ib),
      .remote_output_allocation_param(ro),
      .bus_output_enable_param_a(ea), .bus_output_enable_param_b(eb),
      .output_polarity_param_a(pol), .conn_out_pin(pins),
      .func_in_b(fin));
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e, input string m);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h", $time, m, g);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [31:0] d, e, input logic ab);
      ddio_od_rsp_t r;
      i_ddio_master_model.xfer(w, i, s, d, r);
      chk({30'h0, r.ack, r.abort}, {30'h0, 1'h1, ab}, "response code");
      if (!w && !ab) chk(r.rdata, e, "read data");
   endtask
   task automatic settle();
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // Mask is written ahead of the word, as a master must
   task automatic oc(input logic [15:0] r, input logic [3:0] a, b, p,
      input logic [31:0] m, w, input logic [3:0] e);
      @(posedge core_clk);
      ro <= r;
      ea <= a;
      eb <= b;
      pol <= p;
      acc(1'h1, 16'h60fe, 8'h02, m, 32'h0, 1'h0);
      acc(1'h1, 16'h60fe, 8'h01, w, 32'h0, 1'h0);
      settle();
      chk({28'h0, pins}, {28'h0, e}, "connector outputs");
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      acc(1'h0, 16'h60fe, 8'h01, 32'h0, 32'h0, 1'h0);
      acc(1'h0, 16'h60fe, 8'h02, 32'h0, 32'h0, 1'h0);
      acc(1'h0, 16'h60fe, 8'h00, 32'h0, 32'h2, 1'h0);
      acc(1'h1, 16'h60fe, 8'h00, 32'h5, 32'h0, 1'h1);
      acc(1'h1, 16'h60fd, 8'h00, 32'h0, 32'h0, 1'h1);
      acc(1'h0, 16'h60fd, 8'h01, 32'h0, 32'h0, 1'h1);
      acc(1'h0, 16'h6000, 8'h00, 32'h0, 32'h0, 1'h1);
      acc(1'h1, 16'h60fe, 8'h01, 32'hffffffff, 32'h0, 1'h0);
      acc(1'h0, 16'h60fe, 8'h01, 32'h0, 32'h0f1f0000, 1'h0);
      acc(1'h1, 16'h60fe, 8'h02, 32'hffffffff, 32'h0, 1'h0);
      acc(1'h0, 16'h60fe, 8'h02, 32'h0, 32'h0f1f0000, 1'h0);
      $display("Test registers done");
      foreach (pat[k]) begin
         @(posedge core_clk);
         {cin, sw} <= pat[k];
         settle();
         acc(1'h0, 16'h60fd, 8'h00, 32'h0,
            {11'h0, pat[k][7:3], 13'h0, pat[k][2:0]}, 1'h0);
      end
      $display("Test input image done");
      oc(16'h0, 4'hf, 4'h0, 4'h0,
         32'h0, 32'h0, 4'hf);
      oc(16'h0, 4'hf, 4'h0, 4'h0,
         32'h000f0000, 32'h000a0000, 4'ha);
      oc(16'h0, 4'hf, 4'h0, 4'h3,
         32'h000f0000, 32'h000a0000, 4'h9);
      oc(16'h0, 4'h1, 4'h0, 4'h0,
         32'h000f0000, 32'h0, 4'he);
      // Masked and low, yet no bus enable: must stay inactive
      oc(16'h0, 4'h0, 4'h0, 4'h0,
         32'h000f0000, 32'h0, 4'hf);
      oc(16'h21, 4'hf, 4'h3, 4'h1,
         32'h030f0000, 32'h020f0000, 4'he);
      // Remote bits 26, 27 and an unused remote code on slot 2
      oc(16'h0543, 4'hf, 4'hc, 4'h4,
         32'h0c040000, 32'h04000000, 4'hd);
      @(posedge core_clk);
      ib <= 16'h3210;
      // Slots fed by drive functions, slot 0 inverted
      oc(16'h0, 4'hf, 4'h0, 4'h1,
         32'h000f0000, 32'h000f0000, 4'hb);
      $display("Test outputs done");
      @(posedge core_clk);
      cin <= 5'h1e;
      settle();
      chk({24'h0, fin}, 32'h0000_00fe, "function inputs");
      @(posedge core_clk);
      ia <= 20'h4321f;
      settle();
      chk({24'h0, fin}, 32'h0000_00ff, "remote input used");
      acc(1'h0, 16'h60fd, 8'h00, 32'h0,
         {11'h0, 5'h1e, 13'h0, sw}, 1'h0);
      @(posedge core_clk);
      cin <= 5'h00;
      ia <= 20'hfffff;
      settle();
      chk({24'h0, fin}, 32'h0000_00ff, "all inputs remote");
      $display("Test remote inputs done");
      @(posedge core_clk);
      rst_b <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({28'h0, pins}, 32'h0000_000f, "outputs in reset");
      chk({24'h0, fin}, 32'h0000_00ff, "functions in reset");
      @(posedge core_clk);
      rst_b <= 1'b1;
      acc(1'h0, 16'h60fe, 8'h01, 32'h0, 32'h0, 1'h0);
      acc(1'h0, 16'h60fe, 8'h02, 32'h0, 32'h0, 1'h0);
      $display("Test second reset done");
      tally_and_finish();
   end
endmodule // ddio_top_test
